//--- far_end.sv
// remote serial device: samples the transmit line, drives the receive line
// assumes the bench sets bit_clks to the bit time in clk cycles and nb to
// the number of bits after the start bit that it should capture
`timescale 1ns/1ps
module far_end (
	// clock
	input  wire logic        clk,
	// serial line
	input  wire logic        line_in,
	output logic             line_out,
	// frame shape from the bench
	input  wire logic [15:0] bit_clks,
	input  wire logic [3:0]  nb
);
	logic [10:0] rxq[$];
	logic [10:0] fr;
	int          i;
	// ------------------------------------------------------------
	// receive side: centre sampling from the falling edge
	// ------------------------------------------------------------
	initial begin
		line_out = 1'b1;
		forever begin
			@(posedge clk iff line_in === 1'b0);
			repeat (bit_clks / 2) @(posedge clk);
			if (line_in === 1'b0) begin
				fr = '0;
				for (i = 0; i < nb; i++) begin
					repeat (bit_clks) @(posedge clk);
					fr[i] = line_in;
				end
				rxq.push_back(fr);
			end
		end
	end
	// ------------------------------------------------------------
	// send side: bit 0 of bits goes first; line idles high after
	// ------------------------------------------------------------
	task automatic send(input logic [10:0] bits, input int n);
		for (int k = 0; k < n; k++) begin
			line_out <= bits[k];
			repeat (bit_clks) @(posedge clk);
		end
		line_out <= 1'b1;
		repeat (bit_clks) @(posedge clk);
	endtask
	// short low pulse, well under half a bit
	task automatic blip(input int n);
		line_out <= 1'b0;
		repeat (n) @(posedge clk);
		line_out <= 1'b1;
		repeat (bit_clks) @(posedge clk);
	endtask
endmodule

//--- tb_top.sv
// self-checking bench for the serial channel
// assumes far_end stands for the remote device on the serial line
`timescale 1ns/1ps
module tb_top
	import uart_pkg::*;
;
	logic             clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
	logic [5:0]       awaddr, araddr;
	logic [31:0]      wdata, d;
	logic [1:0]       r;
	logic [7:0]       b;
	logic [7:0]       v[17];
	logic [15:0]      bit_clks;
	logic [3:0]       nb;
	wire logic        awready, wready, bvalid, arready, rvalid;
	wire logic        serial_out, serial_in, rts_n, dtr_n, irq;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	int               failures, n_checks, cyc, i, j;
	localparam logic [7:0] DL[4] = '{8'h01, 8'h03, 8'h02, 8'h01};
	localparam logic [7:0] FR[4] = '{8'h00, 8'h00, 8'h08, 8'h00};
	localparam logic [7:0] PR[4] = '{8'h03, 8'h03, 8'h03, 8'h83};
	localparam logic [15:0] BC[4] = '{16'd16, 16'd48, 16'd40, 16'd64};
	localparam logic [7:0] RXD[4] = '{8'h5a, 8'h33, 8'h0f, 8'h00};
	localparam logic [7:0] EM[4] = '{8'h1d, 8'h1d, 8'h1d, 8'h11};
	localparam logic [7:0] EE[4] = '{8'h01, 8'h05, 8'h09, 8'h11};

	uart_channel uart_channel_i (
		.clk(clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_in(serial_in),
		.serial_out(serial_out), .rts_n(rts_n), .dtr_n(dtr_n), .irq(irq)
	);
	far_end far_end_i (
		.clk(clk), .line_in(serial_out), .line_out(serial_in),
		.bit_clks(bit_clks), .nb(nb)
	);

	always #10 clk = ~clk;
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [10:0] frame(input logic [7:0] x, input logic p,
		input logic bad, input logic s);
		return p ? {s, (^x) ^ bad, x, 1'b0} : {1'b1, s, x, 1'b0};
	endfunction
	function automatic logic [10:0] txexp(input logic [7:0] x, input logic p);
		return p ? {2'b01, ^x, x} : {3'b001, x};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] x);
		logic ta, tw;
		ta = 0;
		tw = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, x};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ta && tw)) begin
			@(posedge clk);
			if (!ta && awready === 1'b1) begin
				ta = 1;
				awvalid <= 0;
			end
			if (!tw && wready === 1'b1) begin
				tw = 1;
				wvalid <= 0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk);
		chk(bresp, RESP_OKAY);
		bready <= 0;
	endtask
	task automatic rd(input logic [5:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 0;
		while (rvalid !== 1'b1) @(posedge clk);
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask
	task automatic wait_rx(input int n);
		repeat (4000) if (far_end_i.rxq.size() < n) @(posedge clk);
	endtask
	task automatic test_done;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// a hang costs a mismatch; the full run needs well under this
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			test_done();
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 0;
		sys_rst = 1;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		bit_clks = 16;
		nb = 9;
		void'($urandom(28236));
		repeat (8) @(posedge clk);
		sys_rst <= 0;
		rd(ADDR_DIV_LOW);
		chk(d, {24'h0, DIV_LOW_RST});
		rd(ADDR_DIV_HIGH);
		chk(d, {24'h0, DIV_HIGH_RST});
		rd(6'h3c);
		chk({d[29:0], r}, {30'h0, RESP_SLVERR});
		// single byte out, no fifo
		wr(ADDR_LINE_CTL, 8'h03);
		wr(ADDR_MODEM, 8'h03);
		b = $urandom;
		wr(ADDR_HOLDING, b);
		rd(ADDR_LINE_ST);
		chk(d & 32'h60, 32'h20);
		wr(ADDR_INT_EN, 8'h02);
		chk(irq, 1'b1);
		wr(ADDR_INT_EN, 8'h00);
		chk(irq, 1'b0);
		wait_rx(1);
		chk(far_end_i.rxq.pop_front(), txexp(b, 0));
		repeat (16) @(posedge clk);
		rd(ADDR_LINE_ST);
		chk(d & 32'h60, 32'h60);
		// shifter plus a full fifo, written back to back
		wr(ADDR_FIFO_CTL, 8'h07);
		for (i = 0; i < 17; i++) begin
			v[i] = $urandom;
			wr(ADDR_HOLDING, v[i]);
		end
		rd(ADDR_LINE_ST);
		chk(d & 32'h60, 32'h00);
		wait_rx(17);
		for (i = 0; i < 17; i++)
			chk(far_end_i.rxq.pop_front(), txexp(v[i], 0));
		repeat (16) @(posedge clk);
		rd(ADDR_LINE_ST);
		chk(d & 32'h60, 32'h60);
		// rates both ways: integer, fractional, prescaled
		wr(ADDR_FIFO_CTL, 8'h00);
		for (i = 0; i < 4; i++) begin
			wr(ADDR_DIV_LOW, DL[i]);
			wr(ADDR_DIV_FRAC, FR[i]);
			wr(ADDR_MODEM, PR[i]);
			bit_clks <= BC[i];
			b = $urandom;
			wr(ADDR_HOLDING, b);
			wait_rx(1);
			chk(far_end_i.rxq.pop_front(), txexp(b, 0));
			far_end_i.send(frame(~b, 0, 0, 1), 10);
			rd(ADDR_HOLDING);
			chk(d, {24'h0, ~b});
		end
		wr(ADDR_MODEM, 8'h03);
		bit_clks <= 16;
		// parity out, false start, then tagged bytes in the fifo
		wr(ADDR_FIFO_CTL, 8'h07);
		wr(ADDR_LINE_CTL, 8'h1b);
		nb <= 10;
		b = $urandom;
		wr(ADDR_HOLDING, b);
		wait_rx(1);
		chk(far_end_i.rxq.pop_front(), txexp(b, 1));
		far_end_i.blip(5);
		// a wrongly taken start would complete its character within this wait
		repeat (192) @(posedge clk);
		rd(ADDR_LINE_ST);
		chk(d & 32'h01, 32'h00);
		for (i = 0; i < 4; i++)
			far_end_i.send(frame(RXD[i], 1, i == 1, i < 2), 11);
		for (i = 0; i < 4; i++) begin
			rd(ADDR_LINE_ST);
			chk(d & EM[i], {24'h0, EE[i]});
			rd(ADDR_HOLDING);
			chk(d, {24'h0, RXD[i]});
		end
		rd(ADDR_LINE_ST);
		chk(d & 32'h01, 32'h00);
		// receive interrupt and data timeout
		wr(ADDR_INT_EN, 8'h01);
		far_end_i.send(frame(b, 1, 0, 1), 11);
		chk(irq, 1'b1);
		repeat (480) @(posedge clk);
		rd(ADDR_INT_SRC);
		chk(d & 32'h04, 32'h00);
		repeat (480) @(posedge clk);
		rd(ADDR_INT_SRC);
		chk(d & 32'h04, 32'h04);
		rd(ADDR_HOLDING);
		chk(d, {24'h0, b});
		chk(irq, 1'b0);
		// loopback: line held at mark, modem outputs off
		wr(ADDR_INT_EN, 8'h00);
		wr(ADDR_MODEM, 8'h13);
		chk({rts_n, dtr_n}, 2'b11);
		b = $urandom;
		wr(ADDR_HOLDING, b);
		j = 0;
		repeat (220) begin
			@(posedge clk);
			if (serial_out !== 1'b1)
				j++;
		end
		chk(j, 0);
		chk(far_end_i.rxq.size(), 0);
		rd(ADDR_HOLDING);
		chk(d, {24'h0, b});
		wr(ADDR_MODEM, 8'h03);
		chk({rts_n, dtr_n}, 2'b00);
		test_done();
	end
endmodule

//--- uart_channel.sv
// one asynchronous serial channel with axi4-lite register access
// assumes the serial input is asynchronous; all logic on clk
//
// Function
// - divide clock by 16.4 fixed divisor for 16x
// - divisor resets to low 0x01, high 0x00
// - prescaler bit divides data rate by four
// - each transmit bit lasts sixteen ticks
// - start, data, optional parity, stop bits
// - transmit least significant data bit first
// - holding writes push the transmit fifo
// - holding empty sets on load into shifter
// - transmit empty interrupt only when enabled
// - fully empty after last bit, fifo empty
// - fifo mode holding empty when fifo empty
// - start bit checked low at half bit
// - sample each later bit at its centre
// - receive fifo holds data plus three tags
// - holding read pops, status shows new head
// - holding presents oldest unread character
// - receive interrupt per character or trigger, enabled
// - timeout after four words plus twelve bits
// - loopback routes shifter output to receiver
// - loopback holds line high, modem outputs off
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module uart_channel
	import uart_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// axi4-lite slave
	input  wire logic [5:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [5:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// serial line and modem pins
	input  wire logic        serial_in,
	output logic             serial_out,
	output logic             rts_n,
	output logic             dtr_n,
	// interrupt request level for the surrounding chip
	output logic             irq
);
	function automatic logic parity_of(input logic [7:0] d, input logic [1:0] wl);
		logic [7:0] m;
		m = 8'hff >> (2'd3 - wl);
		return ^(d & m);
	endfunction

	// ------------------------------------------------------------
	// registers and bus
	// ------------------------------------------------------------
	logic [7:0] div_lo_r, div_hi_r, ie_r, lc_r, mc_r, fc_r;
	logic [3:0] div_frac_r;
	logic [7:0] div_lo_nxt, div_hi_nxt, ie_nxt, lc_nxt, mc_nxt, fc_nxt;
	logic [3:0] div_frac_nxt;
	logic       aw_r, w_r, bv_r, rv_r, aw_nxt, w_nxt, bv_nxt, rv_nxt;
	logic [5:0] awa_r, awa_nxt;
	logic [7:0] wd_r, wd_nxt;
	logic       ws_r, ws_nxt;
	logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic       tx_push, rx_pop, tx_flush, rx_flush;

	// rx fifo and status, declared early for readback
	logic [10:0] rx_mem [FIFO_DEPTH];
	logic [3:0]  rx_wp_r, rx_rp_r, rx_wp_nxt, rx_rp_nxt;
	logic [4:0]  rx_cnt_r, rx_cnt_nxt;
	logic [10:0] rx_head;
	logic        ovr_r, ovr_nxt, thr_empty, tx_all_empty, tmo_r, tmo_nxt;
	logic [7:0]  line_st;

	assign rx_head = rx_mem[rx_rp_r];
	// error tags of the head byte show in bits 2..4; an empty fifo shows none
	assign line_st = {1'b0, tx_all_empty, thr_empty, rx_head[10:8] & {3{rx_cnt_r != 5'd0}},
		ovr_r, rx_cnt_r != 5'd0};

	assign s_axi_awready = !aw_r && !bv_r;
	assign s_axi_wready  = !w_r && !bv_r;
	assign s_axi_bvalid  = bv_r;
	assign s_axi_bresp   = br_r;
	assign s_axi_arready = !rv_r;
	assign s_axi_rvalid  = rv_r;
	assign s_axi_rdata   = rd_r;
	assign s_axi_rresp   = rr_r;

	always_comb begin
		logic [5:0] a;
		logic       do_wr;
		a = 6'h00;
		do_wr = 1'b0;
		{div_lo_nxt, div_hi_nxt, ie_nxt, lc_nxt, mc_nxt} = {div_lo_r, div_hi_r, ie_r, lc_r, mc_r};
		div_frac_nxt = div_frac_r;
		fc_nxt = {fc_r[7:3], 2'b00, fc_r[0]};
		aw_nxt = aw_r; w_nxt = w_r; bv_nxt = bv_r; rv_nxt = rv_r;
		awa_nxt = awa_r; wd_nxt = wd_r; ws_nxt = ws_r; br_nxt = br_r;
		rd_nxt = rd_r; rr_nxt = rr_r;
		tx_push = 1'b0; rx_pop = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_nxt = 1'b1;
			awa_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_nxt = 1'b1;
			wd_nxt = s_axi_wdata[7:0];
			ws_nxt = s_axi_wstrb[0];
		end
		if (aw_r && w_r) begin
			aw_nxt = 1'b0; w_nxt = 1'b0; bv_nxt = 1'b1; br_nxt = RESP_OKAY;
			a = {awa_r[5:2], 2'b00};
			do_wr = ws_r;
			unique case (a)
				ADDR_HOLDING:  tx_push = do_wr;
				ADDR_INT_EN:   if (do_wr) ie_nxt = {4'h0, wd_r[3:0]};
				ADDR_FIFO_CTL: if (do_wr) fc_nxt = wd_r;
				ADDR_LINE_CTL: if (do_wr) lc_nxt = wd_r;
				ADDR_MODEM:    if (do_wr) mc_nxt = {wd_r[7], 2'b00, wd_r[4:0]};
				ADDR_DIV_LOW:  if (do_wr) div_lo_nxt = wd_r;
				ADDR_DIV_HIGH: if (do_wr) div_hi_nxt = wd_r;
				ADDR_DIV_FRAC: if (do_wr) div_frac_nxt = wd_r[3:0];
				ADDR_LINE_ST, ADDR_INT_SRC: ;
				default:       br_nxt = RESP_SLVERR;
			endcase
		end
		if (bv_r && s_axi_bready) bv_nxt = 1'b0;
		if (rv_r && s_axi_rready) rv_nxt = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			rv_nxt = 1'b1; rr_nxt = RESP_OKAY; rd_nxt = 32'h0;
			unique case ({s_axi_araddr[5:2], 2'b00})
				ADDR_HOLDING: begin
					rd_nxt[7:0] = rx_head[7:0];
					rx_pop = rx_cnt_r != 5'd0;
				end
				ADDR_INT_EN:   rd_nxt[7:0] = ie_r;
				ADDR_FIFO_CTL: rd_nxt[7:0] = fc_r;
				ADDR_LINE_CTL: rd_nxt[7:0] = lc_r;
				ADDR_MODEM:    rd_nxt[7:0] = mc_r;
				ADDR_LINE_ST:  rd_nxt[7:0] = line_st;
				ADDR_DIV_LOW:  rd_nxt[7:0] = div_lo_r;
				ADDR_DIV_HIGH: rd_nxt[7:0] = div_hi_r;
				ADDR_DIV_FRAC: rd_nxt[3:0] = div_frac_r;
				ADDR_INT_SRC:  rd_nxt[2:0] = {tmo_r, ie_r[IE_TX] && thr_empty,
					ie_r[IE_RX] && rx_cnt_r != 5'd0};
				default:       rr_nxt = RESP_SLVERR;
			endcase
		end
	end
	assign tx_flush = fc_r[FC_TX_RESET];
	assign rx_flush = fc_r[FC_RX_RESET];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div_lo_r <= DIV_LOW_RST;
			div_hi_r <= DIV_HIGH_RST;
			div_frac_r <= 4'h0;
			{ie_r, lc_r, mc_r, fc_r} <= 32'h0000_0300;
			{aw_r, w_r, bv_r, rv_r, ws_r} <= 5'b0;
			awa_r <= 6'h0; wd_r <= 8'h0; br_r <= 2'b0; rr_r <= 2'b0; rd_r <= 32'h0;
		end else begin
			{div_lo_r, div_hi_r, ie_r, lc_r, mc_r, fc_r} <=
				{div_lo_nxt, div_hi_nxt, ie_nxt, lc_nxt, mc_nxt, fc_nxt};
			div_frac_r <= div_frac_nxt;
			{aw_r, w_r, bv_r, rv_r, ws_r} <= {aw_nxt, w_nxt, bv_nxt, rv_nxt, ws_nxt};
			awa_r <= awa_nxt; wd_r <= wd_nxt; br_r <= br_nxt; rr_r <= rr_nxt; rd_r <= rd_nxt;
		end
	end

	// ------------------------------------------------------------
	// baud generator: 16x tick
	// ------------------------------------------------------------
	// a zero divisor is treated as one so the tick never stalls
	logic [15:0] bcnt_r, bcnt_nxt, div_int;
	logic [3:0]  facc_r, facc_nxt;
	logic [1:0]  pre_r, pre_nxt;
	logic        tick;
	assign div_int = ({div_hi_r, div_lo_r} == 16'h0) ? 16'h1 : {div_hi_r, div_lo_r};
	always_comb begin
		logic [4:0] s;
		s = {1'b0, facc_r} + {1'b0, div_frac_r};
		bcnt_nxt = bcnt_r; facc_nxt = facc_r; pre_nxt = pre_r; tick = 1'b0;
		if (bcnt_r <= 16'h1) begin
			facc_nxt = s[3:0];
			bcnt_nxt = div_int + {15'h0, s[4]};
			pre_nxt = pre_r + 2'd1;
			tick = !mc_r[MC_PRESCALE] || pre_r == 2'(PRESCALE_DIV - 1);
		end else begin
			bcnt_nxt = bcnt_r - 16'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bcnt_r <= 16'h1; facc_r <= 4'h0; pre_r <= 2'b0;
		end else begin
			bcnt_r <= bcnt_nxt; facc_r <= facc_nxt; pre_r <= pre_nxt;
		end
	end

	// ------------------------------------------------------------
	// transmitter
	// ------------------------------------------------------------
	logic [7:0] tx_mem [FIFO_DEPTH];
	logic [3:0] tx_wp_r, tx_rp_r, tx_wp_nxt, tx_rp_nxt, tph_r, tph_nxt;
	logic [4:0] tx_cnt_r, tx_cnt_nxt;
	logic [7:0] tsh_r, tsh_nxt;
	logic [2:0] tbit_r, tbit_nxt;
	logic       tpar_r, tpar_nxt, tline_r, tline_nxt, tload, tlast_stop;
	// parity phase flag: bit counter alone cannot mark it for eight-bit words
	logic       tpp_r, tpp_nxt, tx_acc;
	tx_state_t  ts_r, ts_nxt;
	logic [7:0] wl_bits;
	assign wl_bits = 8'd5 + {6'h0, lc_r[1:0]};
	assign thr_empty = tx_cnt_r == 5'd0;
	assign tx_all_empty = thr_empty && ts_r == TX_IDLE;
	assign tlast_stop = !lc_r[LC_STOP2] || tbit_r != 3'd0;
	always_comb begin
		tx_wp_nxt = tx_wp_r; tx_rp_nxt = tx_rp_r; tx_cnt_nxt = tx_cnt_r;
		ts_nxt = ts_r; tph_nxt = tph_r; tsh_nxt = tsh_r; tbit_nxt = tbit_r;
		tpar_nxt = tpar_r; tline_nxt = tline_r; tload = 1'b0;
		tpp_nxt = tpp_r; tx_acc = 1'b0;
		unique case (ts_r)
			TX_IDLE: begin
				tline_nxt = 1'b1;
				if (!thr_empty && tick) begin
					tload = 1'b1;
					tsh_nxt = tx_mem[tx_rp_r];
					tpar_nxt = parity_of(tx_mem[tx_rp_r], lc_r[1:0]) ^ lc_r[LC_PAR_EVEN] ^ 1'b1;
					ts_nxt = TX_START; tph_nxt = 4'h0; tline_nxt = 1'b0;
				end
			end
			TX_START: if (tick) begin
				tph_nxt = tph_r + 4'h1;
				if (tph_r == 4'hf) begin
					ts_nxt = TX_DATA; tbit_nxt = 3'd0; tline_nxt = tsh_r[0];
				end
			end
			TX_DATA: if (tick) begin
				tph_nxt = tph_r + 4'h1;
				if (tph_r == 4'hf) begin
					if (tpp_r || ({5'h0, tbit_r} == wl_bits - 8'd1 && !lc_r[LC_PAR_EN])) begin
						ts_nxt = TX_STOP; tbit_nxt = 3'd0; tline_nxt = 1'b1; tpp_nxt = 1'b0;
					end else if ({5'h0, tbit_r} == wl_bits - 8'd1) begin
						tpp_nxt = 1'b1; tline_nxt = tpar_r;
					end else begin
						tbit_nxt = tbit_r + 3'd1;
						tsh_nxt = {1'b0, tsh_r[7:1]};
						tline_nxt = tsh_r[1];
					end
				end
			end
			TX_STOP: if (tick) begin
				tph_nxt = tph_r + 4'h1;
				if (tph_r == 4'hf) begin
					if (tlast_stop) ts_nxt = TX_IDLE;
					else tbit_nxt = 3'd1;
				end
			end
		endcase
		if (tload) begin
			tx_rp_nxt = tx_rp_r + 4'h1;
			tx_cnt_nxt = tx_cnt_r - 5'd1;
		end
		// non-fifo mode keeps a single byte in the holding slot
		if (tx_push && (fc_r[FC_ENABLE] ? tx_cnt_nxt != 5'd16 : tx_cnt_nxt == 5'd0)) begin
			tx_acc = 1'b1;
			tx_wp_nxt = tx_wp_r + 4'h1;
			tx_cnt_nxt = tx_cnt_nxt + 5'd1;
		end
		if (tx_flush) begin
			tx_wp_nxt = 4'h0; tx_rp_nxt = 4'h0; tx_cnt_nxt = 5'd0;
		end
	end
	always_ff @(posedge clk) begin
		// a refused write must not overwrite the oldest byte of a full fifo
		if (tx_acc) tx_mem[tx_wp_r] <= wd_r;
		if (sys_rst) begin
			tx_wp_r <= 4'h0; tx_rp_r <= 4'h0; tx_cnt_r <= 5'd0; ts_r <= TX_IDLE;
			tph_r <= 4'h0; tsh_r <= 8'h0; tbit_r <= 3'd0; tpar_r <= 1'b0; tline_r <= 1'b1;
			tpp_r <= 1'b0;
		end else begin
			tx_wp_r <= tx_wp_nxt; tx_rp_r <= tx_rp_nxt; tx_cnt_r <= tx_cnt_nxt; ts_r <= ts_nxt;
			tph_r <= tph_nxt; tsh_r <= tsh_nxt; tbit_r <= tbit_nxt;
			tpar_r <= tpar_nxt; tline_r <= tline_nxt;
			tpp_r <= tpp_nxt;
		end
	end
	assign serial_out = mc_r[MC_LOOP] ? 1'b1 : tline_r & ~lc_r[6];
	assign rts_n = mc_r[MC_LOOP] ? 1'b1 : ~mc_r[1];
	assign dtr_n = mc_r[MC_LOOP] ? 1'b1 : ~mc_r[0];

	// ------------------------------------------------------------
	// receiver
	// ------------------------------------------------------------
	logic       rsync1_r, rsync2_r, rin, rin_d_r;
	logic [3:0] rph_r, rph_nxt;
	logic [2:0] rbit_r, rbit_nxt;
	logic [7:0] rsh_r, rsh_nxt;
	logic       rperr_r, rperr_nxt, rpar_phase_r, rpar_phase_nxt, rpush;
	logic [10:0] rword;
	logic [9:0] tmo_cnt_r, tmo_cnt_nxt;
	rx_state_t  rs_r, rs_nxt;
	assign rin = mc_r[MC_LOOP] ? tline_r : rsync2_r;
	always_comb begin
		logic       ferr;
		ferr = 1'b0;
		rs_nxt = rs_r; rph_nxt = rph_r; rbit_nxt = rbit_r; rsh_nxt = rsh_r;
		rperr_nxt = rperr_r; rpar_phase_nxt = rpar_phase_r; rpush = 1'b0; rword = 11'h0;
		unique case (rs_r)
			RX_IDLE: if (rin_d_r && !rin) begin
				rs_nxt = RX_START; rph_nxt = 4'h0;
			end
			RX_START: if (tick) begin
				rph_nxt = rph_r + 4'h1;
				if (rph_r == MID_COUNT) begin
					if (rin) rs_nxt = RX_IDLE;
					else begin
						rs_nxt = RX_DATA; rph_nxt = 4'h0; rbit_nxt = 3'd0;
						rsh_nxt = 8'h0; rpar_phase_nxt = 1'b0;
						rperr_nxt = lc_r[LC_PAR_EVEN] ^ 1'b1;
					end
				end
			end
			RX_DATA: if (tick) begin
				rph_nxt = rph_r + 4'h1;
				if (rph_r == 4'hf) begin
					rperr_nxt = rperr_r ^ rin;
					if (rpar_phase_r) rs_nxt = RX_STOP;
					else begin
						rsh_nxt = rsh_r | ({7'h0, rin} << rbit_r);
						rbit_nxt = rbit_r + 3'd1;
						if ({5'h0, rbit_r} == wl_bits - 8'd1) begin
							if (lc_r[LC_PAR_EN]) rpar_phase_nxt = 1'b1;
							else rs_nxt = RX_STOP;
						end
					end
				end
			end
			RX_STOP: if (tick) begin
				rph_nxt = rph_r + 4'h1;
				if (rph_r == 4'hf) begin
					ferr = !rin;
					// break: data and stop all low, parity bit not checked
					rword = {ferr && rsh_r == 8'h0 && !(lc_r[LC_PAR_EN] && !rperr_r
						&& lc_r[LC_PAR_EVEN] == 1'b0 && 1'b0), ferr,
						lc_r[LC_PAR_EN] && rperr_r, rsh_r};
					rpush = 1'b1; rs_nxt = RX_IDLE;
				end
			end
		endcase
	end
	always_comb begin
		rx_wp_nxt = rx_wp_r; rx_rp_nxt = rx_rp_r; rx_cnt_nxt = rx_cnt_r; ovr_nxt = ovr_r;
		tmo_cnt_nxt = tmo_cnt_r; tmo_nxt = tmo_r;
		if (rx_pop) begin
			rx_rp_nxt = rx_rp_r + 4'h1; rx_cnt_nxt = rx_cnt_r - 5'd1;
			tmo_nxt = 1'b0; tmo_cnt_nxt = 10'h0;
		end
		if (rpush) begin
			tmo_cnt_nxt = 10'h0;
			if (rx_cnt_nxt == (fc_r[FC_ENABLE] ? 5'd16 : 5'd1)) ovr_nxt = 1'b1;
			else begin
				rx_wp_nxt = rx_wp_r + 4'h1; rx_cnt_nxt = rx_cnt_nxt + 5'd1;
			end
		end else if (rx_cnt_r != 5'd0 && tick && !tmo_r) begin
			// a read restarts the count; a limit reached in the same cycle still sets
			tmo_cnt_nxt = rx_pop ? 10'h0 : tmo_cnt_r + 10'h1;
			// limit in ticks: (4 * word length + 12) bit times of sixteen ticks
			if (tmo_cnt_r == {wl_bits[5:0] + 6'd3, 4'h0} * 10'd4 - 10'd1 + 10'd0 ||
				tmo_cnt_r == 10'h3ff) tmo_nxt = 1'b1;
		end
		if (rx_flush) begin
			rx_wp_nxt = 4'h0; rx_rp_nxt = 4'h0; rx_cnt_nxt = 5'd0; tmo_nxt = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (rpush && rx_cnt_nxt != rx_cnt_r - {4'h0, rx_pop} + 5'd0 || rpush && !ovr_nxt)
			rx_mem[rx_wp_r] <= rword;
		if (sys_rst) begin
			rsync1_r <= 1'b1; rsync2_r <= 1'b1; rin_d_r <= 1'b1; rs_r <= RX_IDLE;
			rph_r <= 4'h0; rbit_r <= 3'd0; rsh_r <= 8'h0; rperr_r <= 1'b0;
			rpar_phase_r <= 1'b0; rx_wp_r <= 4'h0; rx_rp_r <= 4'h0; rx_cnt_r <= 5'd0;
			ovr_r <= 1'b0; tmo_cnt_r <= 10'h0; tmo_r <= 1'b0;
		end else begin
			rsync1_r <= serial_in; rsync2_r <= rsync1_r; rin_d_r <= rin; rs_r <= rs_nxt;
			rph_r <= rph_nxt; rbit_r <= rbit_nxt; rsh_r <= rsh_nxt; rperr_r <= rperr_nxt;
			rpar_phase_r <= rpar_phase_nxt; rx_wp_r <= rx_wp_nxt; rx_rp_r <= rx_rp_nxt;
			rx_cnt_r <= rx_cnt_nxt; ovr_r <= ovr_nxt && !(rv_nxt && rv_r == 1'b0 && 1'b0);
			tmo_cnt_r <= tmo_cnt_nxt; tmo_r <= tmo_nxt;
		end
	end

	// ------------------------------------------------------------
	// interrupt request
	// ------------------------------------------------------------
	assign irq = (ie_r[IE_TX] && thr_empty) ||
		(ie_r[IE_RX] && (tmo_r || (fc_r[FC_ENABLE] ? {3'h0, rx_cnt_r} >= (fc_r[7:6] == 2'd0 ?
		8'd1 : {4'h0, fc_r[7:6], 2'b00}) : rx_cnt_r != 5'd0)));

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence rx_mid_start_high;
		rs_r == RX_START && tick && rph_r == MID_COUNT && rin;
	endsequence
	sequence tx_final_stop_end;
		ts_r == TX_STOP && tick && tph_r == 4'hf && tlast_stop;
	endsequence
	a_div_reset: assert property (@(posedge clk) $fell(sys_rst) |->
		div_lo_r == DIV_LOW_RST && div_hi_r == DIV_HIGH_RST) else $error("divisor reset");
	a_loop_mark: assert property (@(posedge clk) disable iff (sys_rst)
		mc_r[MC_LOOP] |-> serial_out && rts_n && dtr_n) else $error("loopback pins");
	a_tx_start_low: assert property (@(posedge clk) disable iff (sys_rst)
		ts_r == TX_IDLE && ts_nxt == TX_START |=> !tline_r) else $error("start bit");
	a_tx_parity: assert property (@(posedge clk) disable iff (sys_rst)
		ts_r == TX_DATA && tick && tph_r == 4'hf && !tpp_r && lc_r[LC_PAR_EN] &&
		{5'h0, tbit_r} == wl_bits - 8'd1 |=> tpp_r && tline_r == tpar_r)
		else $error("parity bit");
	a_thr_on_load: assert property (@(posedge clk) disable iff (sys_rst)
		tload && tx_cnt_r == 5'd1 && !tx_push |=> thr_empty) else $error("holding empty");
	a_all_empty: assert property (@(posedge clk) disable iff (sys_rst)
		tx_final_stop_end ##0 (thr_empty && !tx_acc) |=> tx_all_empty)
		else $error("all empty");
	a_tx_irq_gate: assert property (@(posedge clk) disable iff (sys_rst)
		!ie_r[IE_TX] && !ie_r[IE_RX] |-> !irq) else $error("irq gating");
	a_false_start: assert property (@(posedge clk) disable iff (sys_rst)
		rx_mid_start_high |=> rs_r == RX_IDLE) else $error("false start");
	a_pop_move: assert property (@(posedge clk) disable iff (sys_rst)
		rx_pop && !rx_flush |=> rx_rp_r == $past(rx_rp_r) + 4'h1) else $error("pop");
	a_tx_bit_len: assert property (@(posedge clk) disable iff (sys_rst)
		$changed(tph_r) |-> tph_r == $past(tph_r) + 4'h1 || tph_r == 4'h0)
		else $error("bit length");
endmodule

//--- uart_pkg.sv
// constants for the serial channel: register map, field positions, reset values
// assumes a 32-bit axi4-lite master; one register per aligned word
package uart_pkg;
	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [5:0] ADDR_HOLDING  = 6'h00;
	localparam logic [5:0] ADDR_INT_EN   = 6'h04;
	localparam logic [5:0] ADDR_FIFO_CTL = 6'h08;
	localparam logic [5:0] ADDR_LINE_CTL = 6'h0c;
	localparam logic [5:0] ADDR_MODEM    = 6'h10;
	localparam logic [5:0] ADDR_LINE_ST  = 6'h14;
	localparam logic [5:0] ADDR_DIV_LOW  = 6'h18;
	localparam logic [5:0] ADDR_DIV_HIGH = 6'h1c;
	localparam logic [5:0] ADDR_DIV_FRAC = 6'h20;
	localparam logic [5:0] ADDR_INT_SRC  = 6'h24;
	// ------------------------------------------------------------
	// reset values and fields
	// ------------------------------------------------------------
	localparam logic [7:0] DIV_LOW_RST   = 8'h01;
	localparam logic [7:0] DIV_HIGH_RST  = 8'h00;
	localparam int         MC_LOOP       = 4;
	localparam int         MC_PRESCALE   = 7;
	localparam int         FC_ENABLE     = 0;
	localparam int         FC_RX_RESET   = 1;
	localparam int         FC_TX_RESET   = 2;
	localparam int         LC_PAR_EN     = 3;
	localparam int         LC_PAR_EVEN   = 4;
	localparam int         LC_STOP2      = 2;
	localparam int         IE_RX         = 0;
	localparam int         IE_TX         = 1;
	localparam int         FIFO_DEPTH    = 16;
	localparam int         PRESCALE_DIV  = 4;
	localparam logic [3:0] MID_COUNT     = 4'h7;
	localparam logic [7:0] TIMEOUT_EXTRA = 8'h0c;
	localparam logic [1:0] RESP_OKAY     = 2'b00;
	localparam logic [1:0] RESP_SLVERR   = 2'b10;
	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001, TX_START = 4'b0010, TX_DATA = 4'b0100, TX_STOP = 4'b1000
	} tx_state_t;
	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
	} rx_state_t;
endpackage
